// ==== hdl/eepw_defs.vh ====
// Constants for the data EEPROM erase/write controller.
// Assumes it is included by bare name from every file of the block.
`ifndef EEPW_DEFS_VH
`define EEPW_DEFS_VH

// Control byte bit positions
`define EEPW_B_TSEL      7
`define EEPW_B_WPERM     6
`define EEPW_B_WTRIG     5
`define EEPW_B_MODE      4
`define EEPW_B_PPERM     3
`define EEPW_B_PTRIG     2

// Reset values and erased byte value
`define EEPW_CTRL_RST    8'h00
`define EEPW_ADDR_RST    10'h000
`define EEPW_DATA_RST    8'h00
`define EEPW_ERASED      8'h00
`define EEPW_TSEL_RST    1'b0
`define EEPW_ADDR_HI_RST 2'h0
`define EEPW_ADDR_LO_RST 8'h00

// Address split: page number over byte offset
`define EEPW_ADDR_W      10
`define EEPW_OFF_W       4
`define EEPW_PAGE_W      6
`define EEPW_OFF_MAX     4'hf
`define EEPW_PAGE_BYTES  16

// Cycle times in ms, clock period in ns
`define EEPW_CLK_NS      5
`define EEPW_T_ER0_MS    3.2
`define EEPW_T_WR0_MS    2.2
`define EEPW_T_ER1_MS    3.7
`define EEPW_T_WR1_MS    3.0
`define EEPW_NS_PER_MS   1000000
`define EEPW_CNT_W       20

`endif

// ==== hdl/eepw_cycle_timer.v ====
// Cycle timer for one erase or write operation.
// Assumes start is a one-cycle pulse and load_val is at least one.
`timescale 1ns/1ps
`include "eepw_defs.vh"

module eepw_cycle_timer #(
    parameter CNT_W = `EEPW_CNT_W
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst,
    // Control
    input  wire             start,
    input  wire [CNT_W-1:0] load_val,
    // Status
    output reg              busy_ff,
    output reg              done_ff
);

    reg [CNT_W-1:0] cnt_ff;

    always @(posedge clock)
    begin
        if (rst)
        begin
            cnt_ff  <= {CNT_W{1'b0}};
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start)
            begin
                cnt_ff  <= load_val;
                busy_ff <= 1'b1;
            end
            else if (busy_ff)
            begin
                if (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1})
                begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ==== hdl/eepw_ctrl.v ====
// Data EEPROM erase/write controller with page buffer and cycle-end interrupt.
// Assumes the CPU presents one register write per cycle on the strobes below.
// How it works
// - Page mode erases the tagged bytes of one 16-byte page
// - Wipe permit falling clears page buffer
// - Program permit falling clears page buffer
// - Page mode data write increments offset only
// - Page erase data write tags address
// - Offset stops at 0FH, later writes not buffered
// - Erase needs permit then trigger, consecutive
// - Erase timed; clear trigger, then permit
// - Erased locations read back zero
// - Write needs permit then trigger, consecutive
// - Byte write erases byte before programming
// - Write timed; clear trigger, then permit
// - Page write loads buffer, offset increments
// - Program permit is zero after reset
// - Interrupt request at every cycle end
// - Set flags; vector only when all enabled
// - Taking interrupt clears global enable
// - Timing select picks cycle durations
`timescale 1ns/1ps
`include "eepw_defs.vh"

module eepw_ctrl #(
    parameter [`EEPW_CNT_W-1:0] ERASE_CYC_0 = `EEPW_T_ER0_MS * `EEPW_NS_PER_MS / `EEPW_CLK_NS,
    parameter [`EEPW_CNT_W-1:0] WRITE_CYC_0 = `EEPW_T_WR0_MS * `EEPW_NS_PER_MS / `EEPW_CLK_NS,
    parameter [`EEPW_CNT_W-1:0] ERASE_CYC_1 = `EEPW_T_ER1_MS * `EEPW_NS_PER_MS / `EEPW_CLK_NS,
    parameter [`EEPW_CNT_W-1:0] WRITE_CYC_1 = `EEPW_T_WR1_MS * `EEPW_NS_PER_MS / `EEPW_CLK_NS,
    parameter                   DEPTH       = 1 << `EEPW_ADDR_W
) (
    // Clock and reset
    input  wire                     clock,
    input  wire                     rst,
    // Control byte write
    input  wire                     ctrl_wr,
    input  wire [7:0]               ctrl_wdata,
    // Address and data writes
    input  wire                     addr_hi_wr,
    input  wire                     addr_lo_wr,
    input  wire                     data_wr,
    input  wire [7:0]               wdata,
    // Array read port
    input  wire [`EEPW_ADDR_W-1:0]  rd_addr,
    output reg  [7:0]               rd_data_ff,
    // Control bits
    output reg                      timing_select_ff,
    output reg                      wipe_permit_ff,
    output reg                      wipe_trigger_ff,
    output reg                      op_mode_ff,
    output reg                      program_permit_ff,
    output reg                      program_trigger_ff,
    // Address and data registers
    output reg  [1:0]               nvm_addr_high_ff,
    output reg  [7:0]               nvm_addr_low_ff,
    output reg  [7:0]               nvm_data_port_ff,
    // Interrupt side
    input  wire                     gie_set,
    input  wire                     gie_clr,
    input  wire                     nvm_irq_enable,
    input  wire                     mf_irq_enable,
    input  wire                     stack_full,
    input  wire                     nvm_flag_clr,
    input  wire                     mf_flag_clr,
    output reg                      global_irq_enable_ff,
    output reg                      nvm_irq_flag_ff,
    output reg                      mf_req_flag_ff,
    output reg                      irq_pulse_ff,
    output reg                      vector_ff
);

    localparam OP_ERASE = 1'b0;
    localparam OP_WRITE = 1'b1;

    // Array and page buffer
    reg [7:0]                  mem [0:DEPTH-1];
    reg [7:0]                  pbuf [0:`EEPW_PAGE_BYTES-1];
    reg [`EEPW_PAGE_BYTES-1:0] tag_ff;
    reg                        stop_ff;

    // Sequencing state
    reg                        warm_ff;
    reg                        parm_ff;
    reg                        op_kind_ff;
    reg                        op_page_ff;
    reg                        fin_ff;
    reg                        fin_kind_ff;

    // Next values
    reg                        nxt_tsel;
    reg                        nxt_mode;
    reg                        nxt_wperm;
    reg                        nxt_wtrig;
    reg                        nxt_pperm;
    reg                        nxt_ptrig;
    reg                        nxt_warm;
    reg                        nxt_parm;
    reg                        start_erase;
    reg                        start_write;
    reg                        buf_clear;
    reg [`EEPW_CNT_W-1:0]      nxt_len;
    reg                        nxt_vector;

    wire                       tmr_busy;
    wire                       tmr_done;
    wire                       ctrl_ok;
    wire [`EEPW_ADDR_W-1:0]    cur_addr;
    wire [`EEPW_OFF_W-1:0]     cur_off;
    wire [`EEPW_PAGE_W-1:0]    cur_page;

    integer i;
    integer j;

    // Done and fin_ff extend the refusal past busy over the tail so permit clearing is not overwritten
    assign ctrl_ok  = ctrl_wr & ~tmr_busy & ~tmr_done & ~fin_ff;
    assign cur_addr = {nvm_addr_high_ff, nvm_addr_low_ff};
    assign cur_off  = cur_addr[`EEPW_OFF_W-1:0];
    assign cur_page = cur_addr[`EEPW_ADDR_W-1:`EEPW_OFF_W];

    function [`EEPW_ADDR_W-1:0] page_addr;
        input [`EEPW_PAGE_W-1:0] page;
        input integer            off;
        begin
            page_addr = {page, off[`EEPW_OFF_W-1:0]};
        end
    endfunction

    eepw_cycle_timer #(
        .CNT_W    (`EEPW_CNT_W)
    ) u_timer (
        .clock    (clock),
        .rst      (rst),
        .start    (start_erase | start_write),
        .load_val (nxt_len),
        .busy_ff  (tmr_busy),
        .done_ff  (tmr_done)
    );

    always @*
    begin
        nxt_tsel    = timing_select_ff;
        nxt_mode    = op_mode_ff;
        nxt_wperm   = wipe_permit_ff;
        nxt_wtrig   = wipe_trigger_ff;
        nxt_pperm   = program_permit_ff;
        nxt_ptrig   = program_trigger_ff;
        nxt_warm    = 1'b0;
        nxt_parm    = 1'b0;
        start_erase = 1'b0;
        start_write = 1'b0;
        if (ctrl_ok)
        begin
            nxt_tsel  = ctrl_wdata[`EEPW_B_TSEL];
            nxt_mode  = ctrl_wdata[`EEPW_B_MODE];
            nxt_wperm = ctrl_wdata[`EEPW_B_WPERM];
            nxt_pperm = ctrl_wdata[`EEPW_B_PPERM];
            // Arm only on the write that raises the permit bit
            nxt_warm  = ctrl_wdata[`EEPW_B_WPERM] & ~wipe_permit_ff;
            nxt_parm  = ctrl_wdata[`EEPW_B_PPERM] & ~program_permit_ff;
            start_erase = ctrl_wdata[`EEPW_B_WTRIG] & ctrl_wdata[`EEPW_B_WPERM] & warm_ff;
            start_write = ctrl_wdata[`EEPW_B_PTRIG] & ctrl_wdata[`EEPW_B_PPERM] & parm_ff
                          & ~start_erase;
            nxt_wtrig = start_erase;
            nxt_ptrig = start_write;
        end
        // Control writes are refused here, so these only clear the running operation's bits
        if (tmr_done)
        begin
            nxt_wtrig = nxt_wtrig & (op_kind_ff != OP_ERASE);
            nxt_ptrig = nxt_ptrig & (op_kind_ff == OP_ERASE);
        end
        if (fin_ff)
        begin
            nxt_wperm = nxt_wperm & (fin_kind_ff != OP_ERASE);
            nxt_pperm = nxt_pperm & (fin_kind_ff == OP_ERASE);
        end
        buf_clear = (wipe_permit_ff & ~nxt_wperm)
                  | (program_permit_ff & ~nxt_pperm);
    end

    // Duration chosen from the select bit as it will stand after this write
    always @*
    begin
        case ({nxt_tsel, start_write})
            2'b00:   nxt_len = ERASE_CYC_0;
            2'b01:   nxt_len = WRITE_CYC_0;
            2'b10:   nxt_len = ERASE_CYC_1;
            2'b11:   nxt_len = WRITE_CYC_1;
            default: nxt_len = ERASE_CYC_0;
        endcase
    end

    // Control bits and sequencing
    always @(posedge clock)
    begin
        if (rst)
        begin
            timing_select_ff   <= `EEPW_TSEL_RST;
            op_mode_ff         <= 1'b0;
            wipe_permit_ff     <= 1'b0;
            wipe_trigger_ff    <= 1'b0;
            program_permit_ff  <= 1'b0;
            program_trigger_ff <= 1'b0;
            warm_ff            <= 1'b0;
            parm_ff            <= 1'b0;
            op_kind_ff         <= OP_ERASE;
            op_page_ff         <= 1'b0;
            fin_ff             <= 1'b0;
            fin_kind_ff        <= OP_ERASE;
        end
        else
        begin
            timing_select_ff   <= nxt_tsel;
            op_mode_ff         <= nxt_mode;
            wipe_permit_ff     <= nxt_wperm;
            wipe_trigger_ff    <= nxt_wtrig;
            program_permit_ff  <= nxt_pperm;
            program_trigger_ff <= nxt_ptrig;
            warm_ff            <= nxt_warm;
            parm_ff            <= nxt_parm;
            fin_ff             <= tmr_done;
            fin_kind_ff        <= op_kind_ff;
            if (start_erase | start_write)
            begin
                op_kind_ff <= start_write ? OP_WRITE : OP_ERASE;
                op_page_ff <= nxt_mode;
            end
        end
    end

    // Address, data register and page buffer
    always @(posedge clock)
    begin
        if (rst)
        begin
            nvm_addr_high_ff <= `EEPW_ADDR_HI_RST;
            nvm_addr_low_ff  <= `EEPW_ADDR_LO_RST;
            nvm_data_port_ff <= `EEPW_DATA_RST;
            tag_ff           <= {`EEPW_PAGE_BYTES{1'b0}};
            stop_ff          <= 1'b0;
            for (i = 0; i < `EEPW_PAGE_BYTES; i = i + 1)
            begin
                pbuf[i] <= `EEPW_DATA_RST;
            end
        end
        else if (buf_clear)
        begin
            tag_ff  <= {`EEPW_PAGE_BYTES{1'b0}};
            stop_ff <= 1'b0;
            for (i = 0; i < `EEPW_PAGE_BYTES; i = i + 1)
            begin
                pbuf[i] <= `EEPW_DATA_RST;
            end
        end
        else if (~tmr_busy)
        begin
            if (addr_hi_wr)
            begin
                nvm_addr_high_ff <= wdata[1:0];
            end
            if (addr_lo_wr)
            begin
                nvm_addr_low_ff <= wdata;
                stop_ff         <= 1'b0;
            end
            else if (data_wr)
            begin
                nvm_data_port_ff <= wdata;
                // Once the offset has stopped, further data is dropped
                if (op_mode_ff & ~stop_ff)
                begin
                    pbuf[cur_off]   <= wdata;
                    tag_ff[cur_off] <= 1'b1;
                    if (cur_off == `EEPW_OFF_MAX)
                    begin
                        stop_ff <= 1'b1;
                    end
                    else
                    begin
                        nvm_addr_low_ff[`EEPW_OFF_W-1:0] <= cur_off + 4'h1;
                    end
                end
            end
        end
    end

    // Array commit at cycle end; the array itself is never reset
    always @(posedge clock)
    begin
        if (tmr_done)
        begin
            if (op_page_ff)
            begin
                for (j = 0; j < `EEPW_PAGE_BYTES; j = j + 1)
                begin
                    if (tag_ff[j])
                    begin
                        if (op_kind_ff == OP_ERASE)
                        begin
                            mem[page_addr(cur_page, j)] <= `EEPW_ERASED;
                        end
                        else
                        begin
                            mem[page_addr(cur_page, j)] <= pbuf[j];
                        end
                    end
                end
            end
            else if (op_kind_ff == OP_ERASE)
            begin
                mem[cur_addr] <= `EEPW_ERASED;
            end
            else
            begin
                // Programming overwrites whole byte, so erase is implicit
                mem[cur_addr] <= nvm_data_port_ff;
            end
        end
        rd_data_ff <= mem[rd_addr];
    end

    // Interrupt request, flags and vectoring
    always @*
    begin
        nxt_vector = global_irq_enable_ff & nvm_irq_enable & mf_irq_enable & ~stack_full
                   & nvm_irq_flag_ff & mf_req_flag_ff & ~vector_ff;
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            irq_pulse_ff         <= 1'b0;
            nvm_irq_flag_ff      <= 1'b0;
            mf_req_flag_ff       <= 1'b0;
            vector_ff            <= 1'b0;
            global_irq_enable_ff <= 1'b0;
        end
        else
        begin
            // Same edge as the trigger bit clears
            irq_pulse_ff    <= tmr_done;
            // Set wins over a software clear in the same cycle
            nvm_irq_flag_ff <= irq_pulse_ff | (nvm_irq_flag_ff & ~nvm_flag_clr);
            mf_req_flag_ff  <= irq_pulse_ff | (mf_req_flag_ff & ~mf_flag_clr);
            vector_ff       <= nxt_vector;
            if (nxt_vector)
            begin
                global_irq_enable_ff <= 1'b0;
            end
            else if (gie_set)
            begin
                global_irq_enable_ff <= 1'b1;
            end
            else if (gie_clr)
            begin
                global_irq_enable_ff <= 1'b0;
            end
        end
    end

endmodule

// ==== bench/eepw_ctrl_monitor.sv ====
// Port-level assertion checker for the EEPROM erase/write controller.
// Assumes it is bound to eepw_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "eepw_defs.vh"

module eepw_ctrl_monitor #(
    parameter [`EEPW_CNT_W-1:0] ERASE_CYC_0 = 20,
    parameter [`EEPW_CNT_W-1:0] ERASE_CYC_1 = 30
) (
    // Clock and reset
    input wire       clock,
    input wire       rst,
    // Software strobes and levels
    input wire       ctrl_wr,
    input wire       addr_hi_wr,
    input wire       addr_lo_wr,
    input wire       data_wr,
    input wire       nvm_irq_enable,
    input wire       mf_irq_enable,
    input wire       stack_full,
    // Control bits and address
    input wire       wipe_permit_ff,
    input wire       wipe_trigger_ff,
    input wire       op_mode_ff,
    input wire       program_permit_ff,
    input wire       program_trigger_ff,
    input wire [1:0] nvm_addr_high_ff,
    input wire [7:0] nvm_addr_low_ff,
    // Interrupt side
    input wire       global_irq_enable_ff,
    input wire       nvm_irq_flag_ff,
    input wire       mf_req_flag_ff,
    input wire       irq_pulse_ff,
    input wire       vector_ff
);
    // Slack of two cycles either way covers start and trigger-clear latency
    localparam int T_LO = ERASE_CYC_0 - 2;
    localparam int T_HI = ERASE_CYC_1 + 2;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_wipe_start;
        $rose(wipe_trigger_ff) |-> $past(ctrl_wr) && $past(ctrl_wr, 2) && $past(wipe_permit_ff)
            && !$past(wipe_permit_ff, 2);
    endproperty
    a_wipe_start: assert property (p_wipe_start) else $error("erase started without permit sequence");
    property p_prog_start;
        $rose(program_trigger_ff) |-> $past(ctrl_wr) && $past(ctrl_wr, 2) && $past(program_permit_ff)
            && !$past(program_permit_ff, 2);
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("write started without permit sequence");
    property p_erase_time;
        $rose(wipe_trigger_ff) |-> ##[T_LO:T_HI] $fell(wipe_trigger_ff);
    endproperty
    a_erase_time: assert property (p_erase_time) else $error("erase cycle length out of range");
    property p_wipe_order;
        $fell(wipe_trigger_ff) |-> wipe_permit_ff ##1 !wipe_permit_ff;
    endproperty
    a_wipe_order: assert property (p_wipe_order) else $error("erase permit not cleared after trigger");
    property p_prog_order;
        $fell(program_trigger_ff) |-> program_permit_ff ##1 !program_permit_ff;
    endproperty
    a_prog_order: assert property (p_prog_order) else $error("write permit not cleared after trigger");
    property p_end_pulse;
        $fell(wipe_trigger_ff) || $fell(program_trigger_ff) |-> irq_pulse_ff ##1 !irq_pulse_ff;
    endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("no single request pulse at cycle end");
    property p_pulse_cause;
        irq_pulse_ff |-> $fell(wipe_trigger_ff) || $fell(program_trigger_ff);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("request pulse without cycle end");
    property p_flags;
        irq_pulse_ff |=> nvm_irq_flag_ff && mf_req_flag_ff;
    endproperty
    a_flags: assert property (p_flags) else $error("flags not set after cycle end");
    property p_vector;
        vector_ff |-> !global_irq_enable_ff && $past(global_irq_enable_ff) && $past(nvm_irq_enable)
            && $past(mf_irq_enable) && !$past(stack_full);
    endproperty
    a_vector: assert property (p_vector) else $error("vector taken without enables");
    property p_off_stop;
        op_mode_ff && data_wr && !addr_lo_wr && nvm_addr_low_ff[3:0] == 4'hf |=> nvm_addr_low_ff[3:0] == 4'hf;
    endproperty
    a_off_stop: assert property (p_off_stop) else $error("offset moved past page end");
    property p_off_inc;
        op_mode_ff && data_wr && !addr_lo_wr && !addr_hi_wr && !wipe_permit_ff && !program_permit_ff
            && !$past(wipe_permit_ff) && !$past(program_permit_ff) && nvm_addr_low_ff[3:0] != 4'hf
            |=> nvm_addr_low_ff == $past(nvm_addr_low_ff) + 8'h01 && $stable(nvm_addr_high_ff);
    endproperty
    a_off_inc: assert property (p_off_inc) else $error("offset not incremented alone");
    property p_reset_perm;
        $fell(rst) |-> !program_permit_ff && !wipe_permit_ff;
    endproperty
    a_reset_perm: assert property (p_reset_perm) else $error("permit set after reset");
endmodule

bind eepw_ctrl eepw_ctrl_monitor #(.ERASE_CYC_0(ERASE_CYC_0), .ERASE_CYC_1(ERASE_CYC_1)) eepw_ctrl_monitor_inst (
    .clock(clock), .rst(rst), .ctrl_wr(ctrl_wr), .addr_hi_wr(addr_hi_wr), .addr_lo_wr(addr_lo_wr),
    .data_wr(data_wr), .nvm_irq_enable(nvm_irq_enable), .mf_irq_enable(mf_irq_enable), .stack_full(stack_full),
    .wipe_permit_ff(wipe_permit_ff), .wipe_trigger_ff(wipe_trigger_ff), .op_mode_ff(op_mode_ff),
    .program_permit_ff(program_permit_ff), .program_trigger_ff(program_trigger_ff),
    .nvm_addr_high_ff(nvm_addr_high_ff), .nvm_addr_low_ff(nvm_addr_low_ff),
    .global_irq_enable_ff(global_irq_enable_ff), .nvm_irq_flag_ff(nvm_irq_flag_ff),
    .mf_req_flag_ff(mf_req_flag_ff), .irq_pulse_ff(irq_pulse_ff), .vector_ff(vector_ff));

// ==== bench/eepw_ctrl_tb.sv ====
// Self-checking bench for the EEPROM erase/write controller.
// Assumes shortened cycle parameters; inputs change on the falling edge.
`timescale 1ns/1ps
`include "eepw_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end

module eepw_ctrl_tb;
    localparam int E0 = 20;
    localparam int E1 = 30;
    localparam int W0 = 10;
    localparam int W1 = 15;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       ctrl_wr = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic       addr_hi_wr = 1'b0;
    logic       addr_lo_wr = 1'b0;
    logic       data_wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [9:0] rd_addr = 10'h000;
    logic       gie_set = 1'b0;
    logic       gie_clr = 1'b0;
    logic       nvm_irq_enable = 1'b0;
    logic       mf_irq_enable = 1'b0;
    logic       stack_full = 1'b0;
    logic       nvm_flag_clr = 1'b0;
    logic       mf_flag_clr = 1'b0;
    wire  [7:0] rd_data_ff;
    wire        timing_select_ff, wipe_permit_ff, wipe_trigger_ff, op_mode_ff;
    wire        program_permit_ff, program_trigger_ff, global_irq_enable_ff;
    wire  [1:0] nvm_addr_high_ff;
    wire  [7:0] nvm_addr_low_ff;
    wire  [7:0] nvm_data_port_ff;
    wire        nvm_irq_flag_ff, mf_req_flag_ff, irq_pulse_ff, vector_ff;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         n_irq = 0;
    int         n_vec = 0;
    int         exp_irq = 0;
    int         i;

    eepw_ctrl #(.ERASE_CYC_0(E0), .ERASE_CYC_1(E1), .WRITE_CYC_0(W0), .WRITE_CYC_1(W1)) eepw_ctrl_inst (
        .clock(clock), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .addr_hi_wr(addr_hi_wr),
        .addr_lo_wr(addr_lo_wr), .data_wr(data_wr), .wdata(wdata), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff),
        .timing_select_ff(timing_select_ff), .wipe_permit_ff(wipe_permit_ff), .wipe_trigger_ff(wipe_trigger_ff),
        .op_mode_ff(op_mode_ff), .program_permit_ff(program_permit_ff), .program_trigger_ff(program_trigger_ff),
        .nvm_addr_high_ff(nvm_addr_high_ff), .nvm_addr_low_ff(nvm_addr_low_ff),
        .nvm_data_port_ff(nvm_data_port_ff), .gie_set(gie_set), .gie_clr(gie_clr),
        .nvm_irq_enable(nvm_irq_enable), .mf_irq_enable(mf_irq_enable), .stack_full(stack_full),
        .nvm_flag_clr(nvm_flag_clr), .mf_flag_clr(mf_flag_clr), .global_irq_enable_ff(global_irq_enable_ff),
        .nvm_irq_flag_ff(nvm_irq_flag_ff), .mf_req_flag_ff(mf_req_flag_ff), .irq_pulse_ff(irq_pulse_ff),
        .vector_ff(vector_ff));

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (irq_pulse_ff === 1'b1)
            n_irq <= n_irq + 1;
        if (vector_ff === 1'b1)
            n_vec <= n_vec + 1;
    end

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Single control write; the trailing idle cycle keeps it from pairing with the next one
    task automatic ctrl(input logic [7:0] v);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(negedge clock);
        ctrl_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic set_addr(input logic [9:0] a);
        addr_hi_wr = 1'b1;
        wdata = {6'h00, a[9:8]};
        @(negedge clock);
        addr_hi_wr = 1'b0;
        addr_lo_wr = 1'b1;
        wdata = a[7:0];
        @(negedge clock);
        addr_lo_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic dw(input int n, input logic [7:0] v0, input logic [7:0] step);
        int j;
        data_wr = 1'b1;
        for (j = 0; j < n; j++)
        begin
            wdata = v0 + step * j[7:0];
            @(negedge clock);
        end
        data_wr = 1'b0;
        @(negedge clock);
    endtask

    // Masks interrupts, activates back to back, sets the global enable, then times the cycle
    task automatic op(input logic [7:0] a, input logic [7:0] b, input int n);
        int k;
        gie_clr = 1'b1;
        @(negedge clock);
        gie_clr = 1'b0;
        ctrl_wr = 1'b1;
        ctrl_wdata = a;
        @(negedge clock);
        ctrl_wdata = b;
        @(negedge clock);
        ctrl_wr = 1'b0;
        gie_set = 1'b1;
        @(negedge clock);
        gie_set = 1'b0;
        k = 1;
        while ((wipe_trigger_ff === 1'b1 || program_trigger_ff === 1'b1) && k < 200)
        begin
            @(negedge clock);
            k++;
        end
        `CHK(k >= n - 1 && k <= n + 2, 1'b1)
        repeat (3) @(negedge clock);
        exp_irq++;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        rd_addr = a;
        @(negedge clock);
        `CHK(rd_data_ff, e)
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        `CHK(program_permit_ff, 1'b0)
        `CHK(wipe_permit_ff, 1'b0)
        $display("test reset done");
        ctrl(8'h10);
        set_addr(10'h020);
        dw(18, 8'h00, 8'h00);
        `CHK(nvm_addr_low_ff, 8'h2f)
        `CHK(op_mode_ff, 1'b1)
        op(8'h50, 8'h70, E0);
        for (i = 0; i < 16; i++)
            rd(10'h020 + i[9:0], 8'h00);
        `CHK({nvm_irq_flag_ff, mf_req_flag_ff}, 2'b11)
        $display("test page_erase done");
        set_addr(10'h020);
        dw(17, 8'h10, 8'h01);
        `CHK(nvm_addr_low_ff, 8'h2f)
        `CHK(nvm_data_port_ff, 8'h20)
        op(8'h98, 8'h9c, W1);
        for (i = 0; i < 16; i++)
            rd(10'h020 + i[9:0], 8'h10 + i[7:0]);
        $display("test page_write done");
        set_addr(10'h024);
        dw(3, 8'h00, 8'h00);
        op(8'hd0, 8'hf0, E1);
        `CHK(timing_select_ff, 1'b1)
        for (i = 0; i < 16; i++)
            rd(10'h020 + i[9:0], (i >= 4 && i <= 6) ? 8'h00 : 8'h10 + i[7:0]);
        $display("test tagged_erase done");
        set_addr(10'h020);
        dw(1, 8'h00, 8'h00);
        ctrl(8'h50);
        ctrl(8'h70);
        `CHK(wipe_trigger_ff, 1'b0)
        ctrl(8'h10);
        op(8'h50, 8'h70, E0);
        rd(10'h020, 8'h10);
        $display("test erase_buffer_clear done");
        set_addr(10'h025);
        dw(1, 8'h66, 8'h00);
        ctrl(8'h18);
        ctrl(8'h10);
        ctrl(8'h14);
        `CHK(program_trigger_ff, 1'b0)
        ctrl(8'h1c);
        `CHK(program_trigger_ff, 1'b0)
        ctrl(8'h10);
        set_addr(10'h024);
        dw(1, 8'h77, 8'h00);
        `CHK(nvm_data_port_ff, 8'h77)
        op(8'h18, 8'h1c, W0);
        rd(10'h024, 8'h77);
        rd(10'h025, 8'h00);
        $display("test write_buffer_clear done");
        `CHK(n_vec, 0)
        `CHK({nvm_irq_flag_ff, mf_req_flag_ff}, 2'b11)
        nvm_flag_clr = 1'b1;
        mf_flag_clr = 1'b1;
        @(negedge clock);
        nvm_flag_clr = 1'b0;
        mf_flag_clr = 1'b0;
        @(negedge clock);
        `CHK({nvm_irq_flag_ff, mf_req_flag_ff}, 2'b00)
        ctrl(8'h00);
        set_addr(10'h021);
        dw(1, 8'h0f, 8'h00);
        stack_full = 1'b1;
        nvm_irq_enable = 1'b1;
        mf_irq_enable = 1'b1;
        op(8'h08, 8'h0c, W0);
        rd(10'h021, 8'h0f);
        `CHK(n_vec, 0)
        stack_full = 1'b0;
        repeat (4) @(negedge clock);
        `CHK(n_vec, 1)
        `CHK(global_irq_enable_ff, 1'b0)
        `CHK(nvm_irq_flag_ff, 1'b1)
        `CHK(n_irq, exp_irq)
        $display("test byte_write_irq done");
        complete_run();
    end
endmodule
